// [irq_agg_pkg.sv]
// shared constants for the two-level interrupt aggregator
package irq_agg_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] PRI_STAT_IDX = 16'h4010;
   localparam logic [15:0] PIN_CFG_IDX = 16'h4017;
   localparam logic [15:0] PRI_MASK_IDX = 16'h4018;
   localparam logic [15:0] SEC_STAT_BASE = 16'h4020;
   localparam logic [15:0] SEC_MASK_BASE = 16'h4030;
   localparam logic [15:0] EVT_STAT_IDX = 16'h4040;
   localparam logic [15:0] EVT_MASK_IDX = 16'h4041;
   // bus shape
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int N_PRI = 16;
   // field positions in the pin configuration register
   localparam int PIN_MASK_BIT = 0;
   localparam int PIN_OD_BIT = 1;
   // primary positions that carry a circuit block
   localparam logic [15:0] PRI_IMPL = 16'hf9b3;
   // reset values
   localparam logic [15:0] PRI_MASK_RST = 16'hffff;
   localparam logic [15:0] SEC_MASK_RST = 16'hffff;
   localparam logic [1:0] PIN_CFG_RST = 2'h0;
   localparam logic [15:0] EVT_MASK_RST = 16'hffff;
   // bus handshake phases
   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } bus_phase_t;
endpackage : irq_agg_pkg

// [sec_event_bank.sv]
// latching secondary events, their masks and the primary OR tree
`timescale 1ns/1ps
`default_nettype none
module sec_event_bank (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // event triggers, one row per primary
   input wire logic [15:0][15:0] trig_in,
   // write strobes from the bus slave
   input wire logic clr_stb_in,
   input wire logic mask_stb_in,
   input wire logic [3:0] sel_in,
   input wire logic [15:0] wdata_in,
   input wire logic [15:0] wbits_in,
   // state seen by the bus and the pin
   output logic [15:0][15:0] stat_out,
   output logic [15:0][15:0] mask_out,
   output logic [15:0] primary_out
);
   typedef struct packed {
      logic [15:0][15:0] stat;
      logic [15:0][15:0] mask;
   } bank_t;
   bank_t st, next_st;
   logic [15:0][15:0] clr, trig;

   // latch, write-one clear and mask update per row
   always_comb begin
      next_st = st;
      for (int i = 0; i < 16; i++) begin
         trig[i] = trig_in[i] & {16{irq_agg_pkg::PRI_IMPL[i]}};
         clr[i] = (clr_stb_in && sel_in == 4'(i)) ?
            (wdata_in & wbits_in) : 16'h0000; // [R2]
         // set beats clear, mask not consulted
         next_st.stat[i] = (st.stat[i] & ~clr[i]) | trig[i]; // [R1] [R12] [R18]
         if (mask_stb_in && sel_in == 4'(i)) begin
            next_st.mask[i] = (st.mask[i] & ~wbits_in) |
               (wdata_in & wbits_in); // [R5]
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st.stat <= '0;
         st.mask <= {16{irq_agg_pkg::SEC_MASK_RST}};
      end else begin
         st <= next_st;
      end
   end

   // primary bit is the OR of unmasked secondaries
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         primary_out[i] = |(st.stat[i] & ~st.mask[i]); // [R4] [R17]
      end
   end
   assign stat_out = st.stat;
   assign mask_out = st.mask;

   latch_hold_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R1]
      1'b1 |=> (($past(st.stat) & ~$past(clr) & ~st.stat) == '0))
      else $error("latched event lost without a clear");
   clear_one_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
      1'b1 |=> (($past(clr) & ~$past(trig) & st.stat) == '0))
      else $error("write of one did not clear event");
   set_wins_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R18]
      1'b1 |=> (($past(trig) & ~st.stat) == '0))
      else $error("trigger lost");
endmodule : sec_event_bank
`default_nettype wire

// [irq_pin_drive.sv]
// request pin drive: enables, output mask and drive type
`timescale 1ns/1ps
`default_nettype none
module irq_pin_drive (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // primary state and pin configuration
   input wire logic [15:0] primary_in,
   input wire logic [15:0] pri_mask_in,
   input wire logic od_sel_in,
   input wire logic out_mask_in,
   // pin level and active-low enable
   output logic pin_out,
   output logic pin_oe_n_out
);
   typedef struct packed {
      logic pin;
      logic oe_n;
   } pin_t;
   pin_t st, next_st;
   logic active;

   // nor of enabled primaries, forced idle by output mask
   always_comb begin
      active = (|(primary_in & ~pri_mask_in)) & ~out_mask_in; // [R7] [R8] [R11]
      next_st = st;
      if (od_sel_in) begin
         next_st.pin = 1'b0; // [R9] [R10]
         next_st.oe_n = ~active;
      end else begin
         next_st.pin = ~active; // [R9]
         next_st.oe_n = 1'b0;
      end
   end

   // one register stage keeps the pin within a cycle
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st.pin <= 1'b1;
         st.oe_n <= 1'b0;
      end else begin
         st <= next_st; // [R19]
      end
   end
   assign pin_out = st.pin;
   assign pin_oe_n_out = st.oe_n;

   sequence od_active_s;
      od_sel_in && active;
   endsequence
   od_drive_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
      od_active_s |=> (!pin_out && !pin_oe_n_out))
      else $error("open drain not pulling low");
   pin_mask_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R11]
      out_mask_in |=> (pin_oe_n_out || pin_out))
      else $error("masked pin shows active");
   cmos_drive_a: assert property (@(posedge clk_in) disable iff (rst_in) // [R7]
      (!od_sel_in && active) |=> (!pin_out && !pin_oe_n_out))
      else $error("push-pull pin not low when active");
endmodule : irq_pin_drive
`default_nettype wire

// [irq_aggregator.sv]
// top: bus slave, primary masks, pin config and event interrupt
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1: secondary bits latch on trigger and hold until cleared
// R2: writing one clears a secondary bit, zero keeps it
// R3: reading secondary registers never changes them
// R4: primary bit is OR of unmasked secondaries in its block
// R5: each secondary has its own mask toward its primary
// R6: primary status register is read-only, writes ignored
// R7: request pin is NOR of enabled primaries, low when any active
// R8: each primary has its own mask toward the request pin
// R9: config bit 1 picks push-pull (0) or open drain (1)
// R10: open drain pulls low when active, releases otherwise
// R11: config bit 0 holds pin inactive regardless of events
// R12: secondaries set even when masked from their primary
// R13: primaries follow secondaries whatever their pin mask
// R14: watchdog reset acts regardless of any interrupt mask
// R15: host reads primary, then secondaries, clears by writing one
// R16: all primary pin masks reset to one
// R17: primary drops only when all its secondaries cleared or masked
// R18: trigger and clear in same cycle leave bit set
// R19: primaries and pin follow changes within one cycle
module irq_aggregator (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // register bus
   input wire logic [17:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // secondary event triggers from circuit blocks
   input wire logic [15:0][15:0] sec_trig_in,
   // watchdog expiry and its reset action
   input wire logic wdog_expire_in,
   output logic wdog_reset_out,
   // active-low request pin
   output logic irq_n_out,
   output logic irq_n_oe_n_out,
   // system interrupt
   output logic irq_level_out
);
   typedef struct packed {
      irq_agg_pkg::bus_phase_t phase;
      logic waitreq;
      logic [31:0] rdata;
      logic [15:0] pri_mask;
      logic [1:0] pin_cfg;
      logic [15:0] pri_prev;
      logic [15:0] evt;
      logic [15:0] evt_mask;
      logic irq_level;
      logic wdog_rst;
   } top_t;
   top_t st, next_st;

   logic [15:0] idx;
   logic acc_wr, acc_rd;
   logic [15:0] wdata, wbits;
   logic clr_stb, mask_stb;
   logic [3:0] sel;
   logic [15:0][15:0] sec_stat, sec_mask;
   logic [15:0] primary;
   logic [15:0] evt_rise;

   // true when an index falls in a 16-entry window
   function automatic logic in_win(input logic [15:0] a,
                                   input logic [15:0] base);
      in_win = (a >= base) && (a < base + 16'h0010);
   endfunction : in_win

   // register index and accepted access
   always_comb begin
      idx = avs_address_in[17:2];
      acc_wr = avs_write_in && st.phase == irq_agg_pkg::BUS_ACK;
      acc_rd = avs_read_in && st.phase == irq_agg_pkg::BUS_ACK;
      wdata = avs_writedata_in[15:0];
      wbits = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
      sel = idx[3:0];
      clr_stb = acc_wr && in_win(idx, irq_agg_pkg::SEC_STAT_BASE);
      mask_stb = acc_wr && in_win(idx, irq_agg_pkg::SEC_MASK_BASE);
   end

   sec_event_bank u_bank (
      .clk_in(ref_clk_in),
      .rst_in(sys_rst_in),
      .trig_in(sec_trig_in),
      .clr_stb_in(clr_stb),
      .mask_stb_in(mask_stb),
      .sel_in(sel),
      .wdata_in(wdata),
      .wbits_in(wbits),
      .stat_out(sec_stat),
      .mask_out(sec_mask),
      .primary_out(primary)
   );

   irq_pin_drive u_pin (
      .clk_in(ref_clk_in),
      .rst_in(sys_rst_in),
      .primary_in(primary), // [R13]
      .pri_mask_in(st.pri_mask),
      .od_sel_in(st.pin_cfg[irq_agg_pkg::PIN_OD_BIT]),
      .out_mask_in(st.pin_cfg[irq_agg_pkg::PIN_MASK_BIT]),
      .pin_out(irq_n_out),
      .pin_oe_n_out(irq_n_oe_n_out)
   );

   // read mux, plain reads only
   function automatic logic [31:0] rd_mux(input logic [15:0] a,
                                          input top_t s,
                                          input logic [15:0] p,
                                          input logic [15:0][15:0] ss,
                                          input logic [15:0][15:0] sm);
      rd_mux = 32'h0000_0000;
      if (a == irq_agg_pkg::PRI_STAT_IDX) begin
         rd_mux[15:0] = p;
      end else if (a == irq_agg_pkg::PIN_CFG_IDX) begin
         rd_mux[1:0] = s.pin_cfg;
      end else if (a == irq_agg_pkg::PRI_MASK_IDX) begin
         rd_mux[15:0] = s.pri_mask;
      end else if (in_win(a, irq_agg_pkg::SEC_STAT_BASE)) begin
         rd_mux[15:0] = ss[a[3:0]]; // [R3]
      end else if (in_win(a, irq_agg_pkg::SEC_MASK_BASE)) begin
         rd_mux[15:0] = sm[a[3:0]];
      end else if (a == irq_agg_pkg::EVT_STAT_IDX) begin
         rd_mux[15:0] = s.evt;
      end else if (a == irq_agg_pkg::EVT_MASK_IDX) begin
         rd_mux[15:0] = s.evt_mask;
      end
   endfunction : rd_mux

   // bus handshake, register writes and event interrupt
   always_comb begin
      next_st = st;
      evt_rise = primary & ~st.pri_prev;
      // one wait cycle per access
      case (st.phase)
         irq_agg_pkg::BUS_IDLE: begin
            if (avs_read_in || avs_write_in) begin
               next_st.phase = irq_agg_pkg::BUS_ACK;
               next_st.waitreq = 1'b0;
               next_st.rdata = avs_read_in ?
                  rd_mux(idx, st, primary, sec_stat, sec_mask) :
                  32'h0000_0000;
            end
         end
         irq_agg_pkg::BUS_ACK: begin
            next_st.phase = irq_agg_pkg::BUS_IDLE;
            next_st.waitreq = 1'b1;
         end
         default: begin
            next_st.phase = irq_agg_pkg::BUS_IDLE;
            next_st.waitreq = 1'b1;
         end
      endcase
      // writes land on the accepting edge; primary status ignores them [R6]
      if (acc_wr && idx == irq_agg_pkg::PRI_MASK_IDX) begin
         next_st.pri_mask = (st.pri_mask & ~wbits) | (wdata & wbits); // [R8]
      end
      if (acc_wr && idx == irq_agg_pkg::PIN_CFG_IDX &&
          avs_byteenable_in[0]) begin
         next_st.pin_cfg = wdata[1:0]; // [R9] [R11]
      end
      if (acc_wr && idx == irq_agg_pkg::EVT_MASK_IDX) begin
         next_st.evt_mask = (st.evt_mask & ~wbits) | (wdata & wbits);
      end
      // primary rising edges are sticky, read clears, set wins
      next_st.pri_prev = primary;
      if (acc_rd && idx == irq_agg_pkg::EVT_STAT_IDX) begin
         next_st.evt = evt_rise;
      end else begin
         next_st.evt = st.evt | evt_rise;
      end
      next_st.irq_level = |(next_st.evt & ~next_st.evt_mask);
      // watchdog action bypasses every mask
      next_st.wdog_rst = wdog_expire_in; // [R14]
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st.phase <= irq_agg_pkg::BUS_IDLE;
         st.waitreq <= 1'b1;
         st.rdata <= 32'h0000_0000;
         st.pri_mask <= irq_agg_pkg::PRI_MASK_RST; // [R16]
         st.pin_cfg <= irq_agg_pkg::PIN_CFG_RST;
         st.pri_prev <= 16'h0000;
         st.evt <= 16'h0000;
         st.evt_mask <= irq_agg_pkg::EVT_MASK_RST;
         st.irq_level <= 1'b0;
         st.wdog_rst <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from flops
   assign avs_readdata_out = st.rdata;
   assign avs_waitrequest_out = st.waitreq;
   assign irq_level_out = st.irq_level;
   assign wdog_reset_out = st.wdog_rst;

   sequence bus_req_s;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence bus_acc_s;
      (avs_read_in || avs_write_in) && !avs_waitrequest_out;
   endsequence
   bus_answer_a: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      bus_req_s |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
      else $error("bus answer not after one wait cycle");
   bus_release_a: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      bus_acc_s |=> avs_waitrequest_out)
      else $error("waitrequest not raised after accept");
   read_keep_a: assert property (@(posedge ref_clk_in) // [R3]
      disable iff (sys_rst_in)
      (acc_rd && in_win(idx, irq_agg_pkg::SEC_STAT_BASE)) |=>
         (($past(sec_stat) & ~sec_stat) == '0))
      else $error("read cleared a secondary event");
   pri_ro_a: assert property (@(posedge ref_clk_in) // [R6]
      disable iff (sys_rst_in)
      (acc_wr && idx == irq_agg_pkg::PRI_STAT_IDX) |=>
         $stable(st.pri_mask) && $stable(sec_mask))
      else $error("write to primary status had an effect");
   mask_reset_a: assert property (@(posedge ref_clk_in) // [R16]
      disable iff (sys_rst_in)
      $fell(sys_rst_in) |-> st.pri_mask == irq_agg_pkg::PRI_MASK_RST)
      else $error("primary masks not set after reset");
   pin_follow_a: assert property (@(posedge ref_clk_in) // [R19]
      disable iff (sys_rst_in)
      (st.pin_cfg == 2'h0 && |(primary & ~st.pri_mask)) |=>
         !irq_n_out)
      else $error("pin did not assert within a cycle");
   wdog_act_a: assert property (@(posedge ref_clk_in) // [R14]
      disable iff (sys_rst_in)
      wdog_expire_in |=> wdog_reset_out)
      else $error("watchdog action suppressed");
   evt_irq_a: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      |(st.evt & ~st.evt_mask) |-> irq_level_out)
      else $error("event interrupt not raised");

   // helper terms for the pin and event checks
   logic pin_cause;
   logic cfg_od;
   logic cfg_mask;
   assign pin_cause = |(primary & ~st.pri_mask);
   assign cfg_od = st.pin_cfg[irq_agg_pkg::PIN_OD_BIT];
   assign cfg_mask = st.pin_cfg[irq_agg_pkg::PIN_MASK_BIT];

   // enabled primary present and output not masked
   sequence pin_on_s;
      pin_cause && !cfg_mask;
   endsequence
   // accepted read of the event status register
   sequence evt_read_s;
      acc_rd && idx == irq_agg_pkg::EVT_STAT_IDX;
   endsequence

   // push-pull always drives, high when nothing asks
   cmos_oe_a: assert property (@(posedge ref_clk_in) // [R9]
      disable iff (sys_rst_in)
      !cfg_od |=> !irq_n_oe_n_out)
      else $error("push-pull pin not driven");
   cmos_idle_a: assert property (@(posedge ref_clk_in) // [R9]
      disable iff (sys_rst_in)
      (!cfg_od && !(pin_cause && !cfg_mask)) |=> irq_n_out)
      else $error("push-pull pin low with no cause");
   // open drain: pull low when asked, release otherwise
   od_low_a: assert property (@(posedge ref_clk_in) // [R10]
      disable iff (sys_rst_in)
      (pin_on_s ##0 cfg_od) |=> (!irq_n_out && !irq_n_oe_n_out))
      else $error("open drain line not pulled low");
   od_release_a: assert property (@(posedge ref_clk_in) // [R10]
      disable iff (sys_rst_in)
      (cfg_od && !(pin_cause && !cfg_mask)) |=> irq_n_oe_n_out)
      else $error("open drain line not released");
   // output mask and primary masks keep the line inactive
   out_mask_a: assert property (@(posedge ref_clk_in) // [R11]
      disable iff (sys_rst_in)
      cfg_mask |=> (irq_n_out || irq_n_oe_n_out))
      else $error("masked output shows a request");
   pri_gate_a: assert property (@(posedge ref_clk_in) // [R8]
      disable iff (sys_rst_in)
      !pin_cause |=> (irq_n_out || irq_n_oe_n_out))
      else $error("masked primary reached the pin");
   // event status: rises are kept, a read leaves only new rises
   evt_set_a: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      (evt_rise != 16'h0000) |=> (($past(evt_rise) & ~st.evt) == 16'h0000))
      else $error("primary rise not recorded");
   evt_clear_a: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      evt_read_s |=> ((st.evt & ~$past(evt_rise)) == 16'h0000))
      else $error("event status not cleared by read");
   // upper half of read data is always zero
   read_upper_a: assert property (@(posedge ref_clk_in)
      disable iff (sys_rst_in)
      !avs_waitrequest_out |-> (avs_readdata_out[31:16] == 16'h0000))
      else $error("read data upper half not zero");
endmodule : irq_aggregator
`default_nettype wire

// [host_model.sv]
// host processor model: bus master and request line servicing
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // clock and bus answer
   input wire logic clk_in,
   input wire logic [31:0] rdata_in,
   input wire logic wait_in,
   // request pin as driven by the device
   input wire logic pin_in,
   input wire logic pin_oe_n_in,
   // bus request
   output logic [17:0] addr_out,
   output logic rd_out,
   output logic wr_out,
   output logic [31:0] wdata_out,
   output logic [3:0] be_out,
   // resolved request line
   output logic line_out
);
   // pull-up wins whenever the device lets go of the line
   assign line_out = pin_oe_n_in ? 1'b1 : pin_in;

   // idle bus at time zero
   initial begin
      addr_out = 18'h0;
      rd_out = 1'b0;
      wr_out = 1'b0;
      wdata_out = 32'h0;
      be_out = 4'hf;
   end

   // one access; request held until waitrequest is seen low
   task automatic access(input logic w, input logic [15:0] idx,
         input logic [15:0] d, output logic [31:0] q);
      @(posedge clk_in);
      addr_out <= {idx, 2'h0};
      wdata_out <= {16'h0, d};
      rd_out <= ~w;
      wr_out <= w;
      // waitrequest and read data are taken at the rising edge itself
      do @(posedge clk_in); while (wait_in !== 1'b0);
      q = rdata_in;
      rd_out <= 1'b0;
      wr_out <= 1'b0;
   endtask : access

   // service: primary first, then flagged rows, clear by writing ones
   task automatic service();
      logic [31:0] pri;
      logic [31:0] sec;
      access(1'b0, irq_agg_pkg::PRI_STAT_IDX, 16'h0, pri);
      for (int p = 0; p < 16; p++) begin
         if (pri[p] === 1'b1) begin
            access(1'b0, irq_agg_pkg::SEC_STAT_BASE + 16'(p), 16'h0,
                   sec);
            access(1'b1, irq_agg_pkg::SEC_STAT_BASE + 16'(p), sec[15:0],
                   sec);
         end
      end
   endtask : service
endmodule : host_model
`default_nettype wire

// [testbench.sv]
// self-checking bench for the two-level interrupt aggregator
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic ref_clk_in;
   logic sys_rst_in;
   logic [17:0] addr;
   logic rd;
   logic wr_q;
   logic [31:0] wdata;
   logic [3:0] be;
   logic [31:0] rdata;
   logic waitreq;
   logic [15:0][15:0] trig;
   logic wdog_in;
   logic wdog_out;
   logic pin;
   logic pin_oe_n;
   logic line;
   logic level;
   int bad_count;
   int checked;
   int cycles = 0;
   localparam logic [15:0] SS = irq_agg_pkg::SEC_STAT_BASE + 16'd13;
   localparam logic [15:0] SM = irq_agg_pkg::SEC_MASK_BASE + 16'd13;

   irq_aggregator dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr_q),
      .avs_writedata_in(wdata), .avs_byteenable_in(be),
      .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
      .sec_trig_in(trig), .wdog_expire_in(wdog_in),
      .wdog_reset_out(wdog_out), .irq_n_out(pin),
      .irq_n_oe_n_out(pin_oe_n), .irq_level_out(level));

   host_model host (.clk_in(ref_clk_in), .rdata_in(rdata),
      .wait_in(waitreq), .pin_in(pin), .pin_oe_n_in(pin_oe_n),
      .addr_out(addr), .rd_out(rd), .wr_out(wr_q), .wdata_out(wdata),
      .be_out(be), .line_out(line));

   // 25 MHz clock
   initial begin
      ref_clk_in = 1'b0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end

   task automatic close_out();
      $display("checked %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   // hang guard
   always @(posedge ref_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         bad_count++;
         close_out();
      end
   end

   task automatic chk(input string n, input logic [31:0] e,
         input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic rc(input logic [15:0] i, input logic [31:0] e,
         input string n);
      logic [31:0] q;
      host.access(1'b0, i, 16'h0, q);
      chk(n, e, q);
   endtask : rc

   task automatic wr(input logic [15:0] i, input logic [15:0] d);
      logic [31:0] q;
      host.access(1'b1, i, d, q);
   endtask : wr

   // let registered outputs follow, then look between edges
   task automatic pins(input logic el, input logic eo, input logic ev);
      repeat (2) @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk("line", {31'h0, el}, {31'h0, line});
      chk("oe_n", {31'h0, eo}, {31'h0, pin_oe_n});
      chk("level", {31'h0, ev}, {31'h0, level});
   endtask : pins

   task automatic pulse(input int p, input int b);
      @(posedge ref_clk_in);
      trig[p][b] <= 1'b1;
      @(posedge ref_clk_in);
      trig[p][b] <= 1'b0;
   endtask : pulse

   task automatic t_reset();
      rc(irq_agg_pkg::PRI_MASK_IDX, 32'hffff, "pri_mask");
      rc(SM, 32'hffff, "sec_mask");
      rc(irq_agg_pkg::PIN_CFG_IDX, 32'h0, "pin_cfg");
      rc(irq_agg_pkg::EVT_MASK_IDX, 32'hffff, "evt_mask");
      rc(16'h4100, 32'h0, "unmapped");
      pins(1'b1, 1'b0, 1'b0);
   endtask : t_reset

   task automatic t_latch();
      pulse(13, 2);
      rc(SS, 32'h0004, "sec_latch");
      rc(irq_agg_pkg::PRI_STAT_IDX, 32'h0, "pri_masked");
      rc(SS, 32'h0004, "sec_reread");
      wr(SM, 16'hffdb);
      rc(irq_agg_pkg::PRI_STAT_IDX, 32'h2000, "pri_or");
      pins(1'b1, 1'b0, 1'b0);
      wr(irq_agg_pkg::PRI_MASK_IDX, 16'hdfff);
      pins(1'b0, 1'b0, 1'b0);
      wr(irq_agg_pkg::PRI_STAT_IDX, 16'h0);
      rc(irq_agg_pkg::PRI_STAT_IDX, 32'h2000, "pri_ro");
   endtask : t_latch

   task automatic t_pincfg();
      wr(irq_agg_pkg::PIN_CFG_IDX, 16'h0002);
      pins(1'b0, 1'b0, 1'b0);
      wr(irq_agg_pkg::PIN_CFG_IDX, 16'h0003);
      pins(1'b1, 1'b1, 1'b0);
      wr(irq_agg_pkg::PIN_CFG_IDX, 16'h0001);
      pins(1'b1, 1'b0, 1'b0);
      wr(irq_agg_pkg::PIN_CFG_IDX, 16'h0000);
   endtask : t_pincfg

   task automatic t_clear();
      pulse(13, 5);
      wr(SS, 16'h0004);
      rc(SS, 32'h0020, "sec_w1c");
      rc(irq_agg_pkg::PRI_STAT_IDX, 32'h2000, "pri_held");
      host.service();
      rc(irq_agg_pkg::PRI_STAT_IDX, 32'h0, "pri_drop");
      pins(1'b1, 1'b0, 1'b0);
   endtask : t_clear

   task automatic t_race();
      pulse(13, 2);
      fork
         wr(SS, 16'h0004);
         begin
            repeat (2) @(posedge ref_clk_in);
            trig[13][2] <= 1'b1;
            @(posedge ref_clk_in);
            trig[13][2] <= 1'b0;
         end
      join
      rc(SS, 32'h0004, "sec_race");
      wr(SS, 16'h0004);
      rc(SS, 32'h0, "sec_after");
   endtask : t_race

   task automatic t_wdog();
      @(posedge ref_clk_in);
      wdog_in <= 1'b1;
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk("wdog", 32'h1, {31'h0, wdog_out});
      @(posedge ref_clk_in);
      wdog_in <= 1'b0;
      @(posedge ref_clk_in);
      @(negedge ref_clk_in);
      chk("wdog_off", 32'h0, {31'h0, wdog_out});
   endtask : t_wdog

   task automatic t_event();
      rc(irq_agg_pkg::EVT_STAT_IDX, 32'h2000, "evt_sticky");
      wr(irq_agg_pkg::EVT_MASK_IDX, 16'hdfff);
      pins(1'b1, 1'b0, 1'b0);
      pulse(13, 2);
      pins(1'b0, 1'b0, 1'b1);
      rc(irq_agg_pkg::EVT_STAT_IDX, 32'h2000, "evt_stat");
      pins(1'b0, 1'b0, 1'b0);
      wr(SS, 16'h0004);
      pins(1'b1, 1'b0, 1'b0);
   endtask : t_event

   // main sequence
   initial begin
      bad_count = 0;
      checked = 0;
      trig = '0;
      wdog_in = 1'b0;
      sys_rst_in = 1'b1;
      repeat (20) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      t_reset();
      t_latch();
      t_pincfg();
      t_clear();
      t_race();
      t_wdog();
      t_event();
      close_out();
   end
endmodule : testbench
`default_nettype wire
